// ### hw/lgc_pkg.sv
// constants, register map and shared helpers for the led_master_request gating control block
// assumes one 50 MHz clock shared by every module of the block
package lgc_pkg;

  // clock and timing
  localparam int CLK_FREQ_HZ       = 50_000_000;
  localparam int ON_DELAY_MS       = 100;
  localparam int ON_DELAY_CYCLES   = CLK_FREQ_HZ / 1000 * ON_DELAY_MS;
  localparam int SAR_SETTLE_CYCLES = 1024;

  // widths
  localparam int PWM_BITS   = 8;
  localparam int APB_ADDR_W = 12;

  // register byte offsets
  localparam logic [APB_ADDR_W-1:0] OFF_CTRL   = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFF_DUTY   = 12'h008;
  localparam logic [APB_ADDR_W-1:0] OFF_SAR    = 12'h00C;

  // control register fields
  localparam int CTRL_COLOUR_EN_BIT = 0;
  localparam int CTRL_SW_LED_BIT    = 1;
  localparam int CTRL_SAR_START_BIT = 2;

  // status register fields
  localparam int STAT_DRV_ON_BIT   = 0;
  localparam int STAT_CHOICE_LSB   = 1;
  localparam int STAT_CFG_BIT      = 3;
  localparam int STAT_SAR_BUSY_BIT = 4;
  localparam int STAT_SAR_DONE_BIT = 5;
  localparam int STAT_REQ_BIT      = 6;
  localparam int STAT_WAIT_BIT     = 7;

  // duty register fields
  localparam int DUTY_RED_LSB   = 0;
  localparam int DUTY_GREEN_LSB = 8;
  localparam int DUTY_BLUE_LSB  = 16;

  // reset values
  localparam logic                CTRL_COLOUR_EN_RST = 1'h0;
  localparam logic                CTRL_SW_LED_RST    = 1'h0;
  localparam logic [PWM_BITS-1:0] DUTY_RST           = 8'h80;

  // light source choice codes
  localparam logic [1:0] CHOICE_NONE  = 2'h0;
  localparam logic [1:0] CHOICE_RED   = 2'h1;
  localparam logic [1:0] CHOICE_GREEN = 2'h2;
  localparam logic [1:0] CHOICE_BLUE  = 2'h3;

  // pwm level for a free running counter against a duty value
  function automatic logic pwm_level(input logic [PWM_BITS-1:0] cnt, input logic [PWM_BITS-1:0] duty);
    return cnt < duty;
  endfunction

endpackage

// ### hw/lgc_sync.sv
// two flip-flop synchroniser for asynchronous level inputs
// assumes the inputs are levels that stay put for several clocks
`timescale 1ns/100ps
module lgc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lgc_sync_s;

  lgc_sync_s st_ff;
  lgc_sync_s nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.meta   = async_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.stable;

endmodule

// ### hw/lgc_sar.sv
// successive approximation engine driving the comparator reference pwm
// assumes the comparator result is already synchronised and the external rc filter settles within SETTLE
`timescale 1ns/100ps
module lgc_sar
  import lgc_pkg::*;
#(
  parameter int SETTLE = lgc_pkg::SAR_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // control
  input  wire logic                         start,
  input  wire logic                         cmp_sync,
  // results
  output logic                              ref_pulse,
  output logic                              busy,
  output logic                              done,
  output logic [lgc_pkg::PWM_BITS-1:0]      result
);

  localparam int SET_W = $clog2(SETTLE + 1);
  localparam int IDX_W = $clog2(PWM_BITS);

  typedef enum logic [0:0] {SAR_IDLE, SAR_SETTLE} lgc_sar_e;

  typedef struct packed {
    lgc_sar_e            state;
    logic [IDX_W-1:0]    bit_idx;
    logic [PWM_BITS-1:0] trial;
    logic [SET_W-1:0]    settle_cnt;
    logic [PWM_BITS-1:0] pwm_cnt;
    logic                ref_pulse;
    logic                busy;
    logic                done;
    logic [PWM_BITS-1:0] result;
  } lgc_sar_s;

  lgc_sar_s st_ff;
  lgc_sar_s nxt_st;

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.done    = 1'b0;
    nxt_st.pwm_cnt = st_ff.pwm_cnt + 8'h01;
    unique case (st_ff.state)
      SAR_IDLE: begin
        if (start) begin
          nxt_st.state      = SAR_SETTLE;
          nxt_st.bit_idx    = IDX_W'(PWM_BITS - 1);
          nxt_st.trial      = '0;
          nxt_st.trial[PWM_BITS-1] = 1'b1;
          nxt_st.settle_cnt = '0;
        end
      end
      SAR_SETTLE: begin
        if (st_ff.settle_cnt == SET_W'(SETTLE - 1)) begin
          // comparator high means the sensor sits above the trial level, so the bit stays
          nxt_st.trial[st_ff.bit_idx] = cmp_sync;
          nxt_st.settle_cnt           = '0;
          if (st_ff.bit_idx == '0) begin
            nxt_st.state         = SAR_IDLE;
            nxt_st.done          = 1'b1;
            nxt_st.result        = st_ff.trial;
            nxt_st.result[0]     = cmp_sync;
          end else begin
            nxt_st.bit_idx                     = st_ff.bit_idx - IDX_W'(1);
            nxt_st.trial[st_ff.bit_idx - IDX_W'(1)] = 1'b1;
          end
        end else begin
          nxt_st.settle_cnt = st_ff.settle_cnt + SET_W'(1);
        end
      end
    endcase
    nxt_st.busy = (nxt_st.state == SAR_SETTLE);
    // reference duty follows the trial level; parked low when idle
    nxt_st.ref_pulse = (nxt_st.state == SAR_SETTLE) && pwm_level(st_ff.pwm_cnt, nxt_st.trial);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ref_pulse = st_ff.ref_pulse;
  assign busy      = st_ff.busy;
  assign done      = st_ff.done;
  assign result    = st_ff.result;

endmodule

// ### hw/lgc_top.sv
// led_master_request gating control: driver master enable, light source choice, colour enables, led pwm
// and the light sensor comparator interface, with an apb register slave
// assumes seq_* inputs come from the display sequencer in this clock domain and cfg_image_loaded
// rises once the configuration image has been read from flash
`timescale 1ns/100ps
module lgc_top
  import lgc_pkg::*;
#(
  parameter int ON_DELAY = lgc_pkg::ON_DELAY_CYCLES,
  parameter int SETTLE   = lgc_pkg::SAR_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [lgc_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // system status
  input  wire logic                          led_master_request,
  input  wire logic                          supply_good_hold,
  input  wire logic                          cfg_image_loaded,
  // display sequencer
  input  wire logic [1:0]                    seq_colour,
  input  wire logic                          seq_running,
  // led driver side
  output logic                               led_driver_master_on,
  output logic [1:0]                         light_source_choice,
  output logic                               red_en_out,
  output logic                               red_en_oe,
  output logic                               green_en_out,
  output logic                               green_en_oe,
  output logic                               blue_en_out,
  output logic                               blue_en_oe,
  output logic                               red_pwm,
  output logic                               green_pwm,
  output logic                               blue_pwm,
  // light sensor comparator
  input  wire logic                          comparator_result_in,
  output logic                               comparator_reference_pulse
);

  localparam int DLY_W = $clog2(ON_DELAY + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {LGC_OFF, LGC_WAIT, LGC_ON} lgc_pwr_e;

  typedef struct packed {
    lgc_pwr_e            pwr;
    logic [DLY_W-1:0]    dly_cnt;
    logic                drv_on;
    logic [1:0]          choice;
    logic                colour_arm;
    logic                sw_led_en;
    logic [PWM_BITS-1:0] duty_r;
    logic [PWM_BITS-1:0] duty_g;
    logic [PWM_BITS-1:0] duty_b;
    logic [PWM_BITS-1:0] pwm_cnt;
    logic                pwm_r;
    logic                pwm_g;
    logic                pwm_b;
    logic                en_r;
    logic                en_g;
    logic                en_b;
    logic                col_oe;
    logic                sar_start;
    logic                sar_done_flag;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } lgc_top_state_s;

  lgc_top_state_s      st_ff;
  lgc_top_state_s      nxt_st;

  logic [2:0]          sync_q;
  logic                req_s;
  logic                hold_s;
  logic                cmp_s;
  logic                sar_ref;
  logic                sar_busy;
  logic                sar_done;
  logic [PWM_BITS-1:0] sar_result;
  logic                access;
  logic                wr_fire;
  logic                led_gate;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers and sar engine

  lgc_sync #(
    .WIDTH    (3)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({comparator_result_in, supply_good_hold, led_master_request}),
    .sync_out (sync_q)
  );

  assign req_s  = sync_q[0];
  assign hold_s = sync_q[1];
  assign cmp_s  = sync_q[2];

  lgc_sar #(
    .SETTLE    (SETTLE)
  ) u_sar (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (st_ff.sar_start),
    .cmp_sync  (cmp_s),
    .ref_pulse (sar_ref),
    .busy      (sar_busy),
    .done      (sar_done),
    .result    (sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register decode helpers

  function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr);
    return (addr == OFF_CTRL) || (addr == OFF_STATUS) || (addr == OFF_DUTY) || (addr == OFF_SAR);
  endfunction

  function automatic logic [31:0] reg_read(input lgc_top_state_s s, input logic [APB_ADDR_W-1:0] addr,
                                           input logic busy, input logic [PWM_BITS-1:0] res,
                                           input logic req, input logic cfg);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (addr)
      OFF_CTRL: begin
        d[CTRL_COLOUR_EN_BIT] = s.colour_arm;
        d[CTRL_SW_LED_BIT]    = s.sw_led_en;
      end
      OFF_STATUS: begin
        d[STAT_DRV_ON_BIT]                   = s.drv_on;
        d[STAT_CHOICE_LSB+1:STAT_CHOICE_LSB] = s.choice;
        d[STAT_CFG_BIT]                      = cfg;
        d[STAT_SAR_BUSY_BIT]                 = busy;
        d[STAT_SAR_DONE_BIT]                 = s.sar_done_flag;
        d[STAT_REQ_BIT]                      = req;
        d[STAT_WAIT_BIT]                     = (s.pwr == LGC_WAIT);
      end
      OFF_DUTY: begin
        d[DUTY_RED_LSB+PWM_BITS-1:DUTY_RED_LSB]     = s.duty_r;
        d[DUTY_GREEN_LSB+PWM_BITS-1:DUTY_GREEN_LSB] = s.duty_g;
        d[DUTY_BLUE_LSB+PWM_BITS-1:DUTY_BLUE_LSB]   = s.duty_b;
      end
      OFF_SAR: begin
        d[PWM_BITS-1:0] = res;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  assign access  = psel && penable;
  // a write lands only at the edge where the master sees pready high
  assign wr_fire = access && st_ff.pready && pwrite && reg_hit(paddr);

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.sar_start = 1'b0;
    nxt_st.pwm_cnt   = st_ff.pwm_cnt + 8'h01;

    // apb: one wait state, then answer
    if (access && !st_ff.pready) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !reg_hit(paddr);
      nxt_st.prdata  = pwrite ? 32'h0000_0000 : reg_read(st_ff, paddr, sar_busy, sar_result, req_s,
                                                         cfg_image_loaded);
    end else begin
      nxt_st.pready  = 1'b0;
      nxt_st.pslverr = 1'b0;
    end

    if (wr_fire && (paddr == OFF_CTRL)) begin
      nxt_st.colour_arm = pwdata[CTRL_COLOUR_EN_BIT];
      nxt_st.sw_led_en  = pwdata[CTRL_SW_LED_BIT];
      nxt_st.sar_start  = pwdata[CTRL_SAR_START_BIT] && !sar_busy;
    end
    if (wr_fire && (paddr == OFF_DUTY)) begin
      nxt_st.duty_r = pwdata[DUTY_RED_LSB+PWM_BITS-1:DUTY_RED_LSB];
      nxt_st.duty_g = pwdata[DUTY_GREEN_LSB+PWM_BITS-1:DUTY_GREEN_LSB];
      nxt_st.duty_b = pwdata[DUTY_BLUE_LSB+PWM_BITS-1:DUTY_BLUE_LSB];
    end

    // done flag: write one to clear, a finishing conversion in the same cycle wins
    if (wr_fire && (paddr == OFF_STATUS) && pwdata[STAT_SAR_DONE_BIT]) begin
      nxt_st.sar_done_flag = 1'b0;
    end
    if (sar_done) begin
      nxt_st.sar_done_flag = 1'b1;
    end

    // power-on delay sequencing of the driver master enable
    unique case (st_ff.pwr)
      LGC_OFF: begin
        // starting from off with the request high counts as a fresh rise
        if (req_s && hold_s) begin
          nxt_st.pwr     = LGC_WAIT;
          nxt_st.dly_cnt = '0;
        end
      end
      LGC_WAIT: begin
        if (!req_s || !hold_s) begin
          nxt_st.pwr = LGC_OFF;
        end else if (st_ff.dly_cnt == DLY_W'(ON_DELAY - 1)) begin
          nxt_st.pwr = LGC_ON;
        end else begin
          nxt_st.dly_cnt = st_ff.dly_cnt + DLY_W'(1);
        end
      end
      LGC_ON: begin
        if (!req_s || !hold_s) begin
          nxt_st.pwr = LGC_OFF;
        end
      end
    endcase

    nxt_st.drv_on = (nxt_st.pwr == LGC_ON);
    // choice tracks the sequencer only while the driver is released
    if ((nxt_st.pwr == LGC_ON) && seq_running) begin
      nxt_st.choice = seq_colour;
    end else begin
      nxt_st.choice = CHOICE_NONE;
    end

    // colour pins turn into driven-low outputs once the image is loaded
    nxt_st.col_oe = cfg_image_loaded;
    nxt_st.en_r   = cfg_image_loaded && st_ff.colour_arm && (st_ff.choice == CHOICE_RED);
    nxt_st.en_g   = cfg_image_loaded && st_ff.colour_arm && (st_ff.choice == CHOICE_GREEN);
    nxt_st.en_b   = cfg_image_loaded && st_ff.colour_arm && (st_ff.choice == CHOICE_BLUE);

    // pwm high is the led-off level for the driver, hence forced high when gated
    nxt_st.pwm_r = !led_gate || pwm_level(st_ff.pwm_cnt, st_ff.duty_r);
    nxt_st.pwm_g = !led_gate || pwm_level(st_ff.pwm_cnt, st_ff.duty_g);
    nxt_st.pwm_b = !led_gate || pwm_level(st_ff.pwm_cnt, st_ff.duty_b);
  end

  assign led_gate = st_ff.drv_on && st_ff.sw_led_en && seq_running;

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff            <= '0;
      st_ff.pwr        <= LGC_OFF;
      st_ff.colour_arm <= CTRL_COLOUR_EN_RST;
      st_ff.sw_led_en  <= CTRL_SW_LED_RST;
      st_ff.duty_r     <= DUTY_RST;
      st_ff.duty_g     <= DUTY_RST;
      st_ff.duty_b     <= DUTY_RST;
      st_ff.pwm_r      <= 1'b1;
      st_ff.pwm_g      <= 1'b1;
      st_ff.pwm_b      <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign prdata                     = st_ff.prdata;
  assign pready                     = st_ff.pready;
  assign pslverr                    = st_ff.pslverr;
  assign led_driver_master_on       = st_ff.drv_on;
  assign light_source_choice        = st_ff.choice;
  assign red_en_out                 = st_ff.en_r;
  assign green_en_out               = st_ff.en_g;
  assign blue_en_out                = st_ff.en_b;
  assign red_en_oe                  = st_ff.col_oe;
  assign green_en_oe                = st_ff.col_oe;
  assign blue_en_oe                 = st_ff.col_oe;
  assign red_pwm                    = st_ff.pwm_r;
  assign green_pwm                  = st_ff.pwm_g;
  assign blue_pwm                   = st_ff.pwm_b;
  assign comparator_reference_pulse = sar_ref;

endmodule

// ### verif/lgc_top_assertions.sv
// checker for lgc_top: power gating, choice code, colour enables and led pwm forcing
// assumes it sees only the top ports; it is bound to lgc_top at the foot of this file
`timescale 1ns/100ps
module lgc_top_assertions
  import lgc_pkg::*;
#(
  parameter int ON_DELAY = 20
) (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic                  pready,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  // system and sequencer
  input wire logic                  led_master_request,
  input wire logic                  supply_good_hold,
  input wire logic [1:0]            seq_colour,
  input wire logic                  seq_running,
  // led side
  input wire logic                  led_driver_master_on,
  input wire logic [1:0]            light_source_choice,
  input wire logic                  red_en_out,
  input wire logic                  green_en_out,
  input wire logic                  blue_en_out,
  input wire logic                  red_pwm,
  input wire logic                  green_pwm,
  input wire logic                  blue_pwm
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  int         hi_cnt_ff;
  logic [1:0] ctrl_ff;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_ff <= 0;
      ctrl_ff   <= 2'h0;
    end else begin
      // saturates so a long on period cannot wrap it
      hi_cnt_ff <= !(led_master_request && supply_good_hold) ? 0 : hi_cnt_ff + (hi_cnt_ff < ON_DELAY + 8);
      if (psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
        ctrl_ff <= pwdata[1:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_req_low;
    !led_master_request [*3] |=> !led_driver_master_on && light_source_choice == CHOICE_NONE;
  endproperty
  a_req_low: assert property (p_req_low) else $error("driver on while request low");
  property p_hold_low;
    !supply_good_hold [*3] |=> !led_driver_master_on;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("driver on while hold low");
  property p_no_early_on;
    $rose(led_driver_master_on) |-> hi_cnt_ff >= ON_DELAY + 2;
  endproperty
  a_no_early_on: assert property (p_no_early_on) else $error("driver on before delay");
  property p_on_late;
    hi_cnt_ff == ON_DELAY + 7 |-> led_driver_master_on;
  endproperty
  a_on_late: assert property (p_on_late) else $error("driver not on after delay");
  property p_choice;
    light_source_choice == (led_driver_master_on && $past(seq_running) ? $past(seq_colour) : CHOICE_NONE);
  endproperty
  a_choice: assert property (p_choice) else $error("choice code wrong");
  property p_red;
    red_en_out |-> $past(light_source_choice) == CHOICE_RED;
  endproperty
  a_red: assert property (p_red) else $error("red on without red choice");
  property p_green;
    green_en_out |-> $past(light_source_choice) == CHOICE_GREEN;
  endproperty
  a_green: assert property (p_green) else $error("green on without green choice");
  property p_blue;
    blue_en_out |-> $past(light_source_choice) == CHOICE_BLUE;
  endproperty
  a_blue: assert property (p_blue) else $error("blue on without blue choice");
  property p_en_gate;
    red_en_out || green_en_out || blue_en_out |-> $past(ctrl_ff[0]);
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("colour on before enable write");
  property p_pwm_forced;
    !($past(led_driver_master_on) && $past(ctrl_ff[1]) && $past(seq_running)) |-> red_pwm && green_pwm && blue_pwm;
  endproperty
  a_pwm_forced: assert property (p_pwm_forced) else $error("pwm not forced high");
endmodule

bind lgc_top lgc_top_assertions #(.ON_DELAY(ON_DELAY)) lgc_top_assertions_inst (.*);

// ### verif/lgc_far_side.sv
// far side model: light sensor comparator facing the block's reference pwm
// assumes the bench gives the sensor level as above or below any trial level
`timescale 1ns/100ps
module lgc_far_side (
  // clock
  input  wire logic pclk,
  // analog side
  input  wire logic sensor_high,
  input  wire logic ref_pulse,
  // comparator and monitor
  output logic      comparator_result_in,
  output int        ref_cnt
);
  initial ref_cnt = 0;
  // comparator changes off the block's timing; the block must synchronise it
  always @(negedge pclk) comparator_result_in <= sensor_high;
  always @(posedge pclk) begin
    if (ref_pulse === 1'b1) begin
      ref_cnt <= ref_cnt + 1;
    end
  end
endmodule

// ### verif/led_master_request_gating_control_tb_top.sv
// testbench for lgc_top: apb register tasks, power sequence, colour, pwm and sar scenarios
// assumes the checker is bound to lgc_top and the far side model drives the comparator
`timescale 1ns/100ps
module led_master_request_gating_control_tb_top;
  import lgc_pkg::*;
  localparam int OND = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sensor_high;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        led_master_request, supply_good_hold, cfg_image_loaded, seq_running;
  logic [1:0]  seq_colour, light_source_choice;
  logic        led_driver_master_on, red_en_out, red_en_oe, green_en_out, green_en_oe;
  logic        blue_en_out, blue_en_oe, red_pwm, green_pwm, blue_pwm;
  logic        comparator_result_in, comparator_reference_pulse;
  int          err_count = 0, check_count = 0, n, k, m, c [3];
  int          ref_cnt_w;

  // 32 settle cycles per bit make one conversion span a full 256-cycle reference period
  lgc_top #(.ON_DELAY(OND), .SETTLE(32)) lgc_top_inst (.*);
  lgc_far_side lgc_far_side_inst (.pclk(pclk), .sensor_high(sensor_high), .ref_pulse(comparator_reference_pulse),
    .comparator_result_in(comparator_result_in), .ref_cnt(ref_cnt_w));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic expire(input logic ok);
    if (ok !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int t);
    repeat (t) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 8);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    expire(pready);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_on();
    for (k = 0; k < OND + 12 && led_driver_master_on !== 1'b1; k++) @(posedge pclk);
    expire(led_driver_master_on);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, led_master_request, cfg_image_loaded, seq_running, seq_colour} = '0;
    {supply_good_hold, sensor_high} = 2'h0;
    tick(4);
    chk({red_pwm, green_pwm, blue_pwm, led_driver_master_on, light_source_choice, red_en_oe}, 7'h70);
    presetn <= 1'b1;
    rdchk(OFF_DUTY, 32'h00808080);
    rdchk(OFF_CTRL, 32'h0);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk(er, 1'b1);
    rdchk(12'h010, 32'h0);
    chk(er, 1'b1);
    $display("test registers done");
    {cfg_image_loaded, seq_running, led_master_request, supply_good_hold} <= 4'hF;
    seq_colour <= CHOICE_RED;
    tick(OND);
    chk(led_driver_master_on, 1'b0);
    chk({red_en_oe, green_en_oe, blue_en_oe, red_en_out}, 4'hE);
    wait_on();
    tick(2);
    chk(light_source_choice, CHOICE_RED);
    chk(red_en_out, 1'b0);
    rdchk(OFF_STATUS, 32'h4B);
    apb(1'b1, OFF_CTRL, 32'h3);
    for (n = 0; n < 4; n++) begin
      seq_colour <= n[1:0];
      tick(4);
      chk(light_source_choice, n[1:0]);
      chk({blue_en_out, green_en_out, red_en_out}, (3'h1 << n) >> 1);
    end
    $display("test power and colour done");
    apb(1'b1, OFF_DUTY, 32'h00C04020);
    c = '{0, 0, 0};
    tick(4);
    repeat (256) begin
      @(posedge pclk);
      c[0] += red_pwm;
      c[1] += green_pwm;
      c[2] += blue_pwm;
    end
    chk({c[0][15:0], c[1][7:0], c[2][7:0]}, 32'h002040C0);
    seq_running <= 1'b0;
    tick(5);
    chk({red_pwm, green_pwm, blue_pwm}, 3'h7);
    seq_running <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h1);
    tick(5);
    chk({red_pwm, green_pwm, blue_pwm}, 3'h7);
    $display("test pwm done");
    supply_good_hold <= 1'b0;
    tick(5);
    chk({led_driver_master_on, light_source_choice}, 3'h0);
    supply_good_hold <= 1'b1;
    tick(OND / 2);
    led_master_request <= 1'b0;
    tick(5);
    chk({led_driver_master_on, light_source_choice}, 3'h0);
    led_master_request <= 1'b1;
    tick(OND);
    chk(led_driver_master_on, 1'b0);
    wait_on();
    $display("test drop done");
    for (n = 0; n < 2; n++) begin
      sensor_high <= ~n[0];
      m = ref_cnt_w;
      apb(1'b1, OFF_CTRL, 32'h7);
      k = 0;
      do begin
        apb(1'b0, OFF_STATUS, 32'h0);
        k++;
      end while (rd[STAT_SAR_DONE_BIT] !== 1'b1 && k < 120);
      expire(rd[STAT_SAR_DONE_BIT]);
      rdchk(OFF_SAR, {24'h0, {8{~n[0]}}});
      chk(ref_cnt_w > m, 1'b1);
      chk(comparator_reference_pulse, 1'b0);
      apb(1'b1, OFF_STATUS, 32'h20);
    end
    $display("test sar done");
    tally_and_finish();
  end
endmodule
